// ===== design/pointer_ram.sv
// Internal RAM window reached through the pointer; holds bulk buffers of 64 bytes.
// Assumes one access per cycle; read data registered one cycle after the read.
`timescale 1ns/1ps
`default_nettype none
`include "ram_pointer_cfg.svh"
module pointer_ram (
  // Clock and enable
  input  wire logic                    core_clk,
  input  wire logic                    clk_en,
  // Access port
  input  wire ram_pointer_pkg::ram_addr_type addr,
  input  wire logic                    wr_en,
  input  wire ram_pointer_pkg::byte_type     wr_data,
  output logic [`PTR_DATA_W-1:0]       rd_data
);
  // Only the low index bits decode; higher pointer bits alias the window
  logic [`PTR_DATA_W-1:0] mem [0:`PTR_RAM_DEPTH-1];
  logic [`PTR_DATA_W-1:0] rd_data_r;
  logic [`PTR_DATA_W-1:0] rd_data_nxt;
  logic [`PTR_RAM_IDX_W-1:0] idx;

  always_comb begin
    idx         = addr[`PTR_RAM_IDX_W-1:0];
    rd_data_nxt = mem[idx];
  end

  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[idx] <= wr_data;
      end
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;
endmodule : pointer_ram
`default_nettype wire

// ===== design/ram_pointer.sv
// Auto-incrementing RAM pointer: high/low address registers and a data port.
// Assumes the bus master issues one-cycle strobes, never read and write together.
//
// Behaviour
// - Bulk endpoint data lives in 64-byte RAM buffers reachable by the pointer.
// - A dedicated pointer steps its address by one per byte moved.
// - Any contiguous RAM run is read or written as a FIFO without address math.
// - Buffer contents are streamed through one data port register.
// - High register bits 6..0 hold address bits 14..8; reset value 0.
// - Low register bits 7..0 hold address bits 7..0.
// - Each data port access uses the stored address, then increments it.
// - Address registers are readable and writable anytime; reads show next location.
`timescale 1ns/1ps
`default_nettype none
`include "ram_pointer_cfg.svh"
module ram_pointer (
  // Clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  // Register port
  input  wire logic [`PTR_ADDR_W-1:0]  reg_addr,
  input  wire logic [`PTR_DATA_W-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [`PTR_DATA_W-1:0]       reg_rdata,
  // Current pointer for observation
  output logic [`PTR_RAM_AW-1:0]       ptr_addr
);
  // Address decode, shared by read and write paths
  function automatic ram_pointer_pkg::reg_sel_type decode(input logic [`PTR_ADDR_W-1:0] a);
    if (a == `PTR_HIGH_OFFSET) begin
      decode = ram_pointer_pkg::SEL_HIGH;
    end else if (a == `PTR_LOW_OFFSET) begin
      decode = ram_pointer_pkg::SEL_LOW;
    end else if (a == `PTR_DATA_OFFSET) begin
      decode = ram_pointer_pkg::SEL_DATA;
    end else begin
      decode = ram_pointer_pkg::SEL_NONE;
    end
  endfunction : decode

  // Byte seen when the upper register is read; bit 7 has no storage
  function automatic ram_pointer_pkg::byte_type high_view(input logic [`PTR_HIGH_W-1:0] h);
    high_view = {1'b0, h};
  endfunction : high_view

  // Upper half after a software write; bit 7 of the byte is dropped
  function automatic logic [`PTR_HIGH_W-1:0] high_load(input ram_pointer_pkg::byte_type d);
    high_load = d[`PTR_HIGH_MSB:0];
  endfunction : high_load

  // Both halves side by side as one RAM address
  function automatic ram_pointer_pkg::ram_addr_type join_ptr(input logic [`PTR_HIGH_W-1:0] h,
                                                             input ram_pointer_pkg::byte_type l);
    join_ptr = {h, l};
  endfunction : join_ptr

  // One-byte step of the whole pointer
  function automatic ram_pointer_pkg::ram_addr_type step(input ram_pointer_pkg::ram_addr_type p);
    logic [`PTR_RAM_AW:0] wide;
    wide = {1'b0, p} + 16'h0001;
    // Carry out of the top bit is dropped, so the pointer wraps to zero
    step = wide[`PTR_RAM_AW-1:0];
  endfunction : step

  // Byte returned by a register read; the data port is answered by the RAM instead
  function automatic ram_pointer_pkg::byte_type reg_view(input ram_pointer_pkg::reg_sel_type s,
                                                         input logic [`PTR_HIGH_W-1:0] h,
                                                         input ram_pointer_pkg::byte_type l);
    reg_view = `PTR_UNMAPPED_READ;
    unique case (s)
      ram_pointer_pkg::SEL_HIGH: begin
        reg_view = high_view(h);
      end
      ram_pointer_pkg::SEL_LOW: begin
        reg_view = l;
      end
      ram_pointer_pkg::SEL_DATA: begin
        reg_view = `PTR_UNMAPPED_READ;
      end
      ram_pointer_pkg::SEL_NONE: begin
        reg_view = `PTR_UNMAPPED_READ;
      end
    endcase
  endfunction : reg_view

  // Decoded request
  ram_pointer_pkg::reg_sel_type  sel;
  logic                          high_wr;
  logic                          low_wr;
  logic                          data_wr;
  logic                          data_rd;
  logic                          data_access;
  // Pointer halves, one per address register
  logic [`PTR_HIGH_W-1:0]        ptr_high_r;
  logic [`PTR_HIGH_W-1:0]        ptr_high_nxt;
  ram_pointer_pkg::byte_type     ptr_low_r;
  ram_pointer_pkg::byte_type     ptr_low_nxt;
  ram_pointer_pkg::ram_addr_type ptr_cur;
  ram_pointer_pkg::ram_addr_type ptr_step;
  // Read answer pipeline
  ram_pointer_pkg::reg_sel_type  rd_sel_r;
  ram_pointer_pkg::reg_sel_type  rd_sel_nxt;
  logic [`PTR_DATA_W-1:0]        rd_hold_r;
  logic [`PTR_DATA_W-1:0]        rd_hold_nxt;
  // RAM side
  logic [`PTR_DATA_W-1:0]        ram_rdata;
  logic                          ram_wr;

  // Request decode: strobes never coincide, so at most one of these is high
  always_comb begin
    sel     = decode(reg_addr);
    high_wr = 1'b0;
    low_wr  = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    unique case (sel)
      ram_pointer_pkg::SEL_HIGH: begin
        high_wr = reg_wr;
      end
      ram_pointer_pkg::SEL_LOW: begin
        low_wr = reg_wr;
      end
      ram_pointer_pkg::SEL_DATA: begin
        data_wr = reg_wr;
        data_rd = reg_rd;
      end
      ram_pointer_pkg::SEL_NONE: begin
      end
    endcase
    data_access = data_wr || data_rd;
    ram_wr      = data_wr;
  end

  // The RAM always sees the stored pointer; the step is applied at the access edge
  always_comb begin
    ptr_cur  = join_ptr(ptr_high_r, ptr_low_r);
    ptr_step = step(ptr_cur);
  end

  // Upper address register; a data access may carry into it from the low byte
  always_comb begin
    ptr_high_nxt = ptr_high_r;
    if (high_wr) begin
      ptr_high_nxt = high_load(reg_wdata);
    end else if (data_access) begin
      ptr_high_nxt = ptr_step[`PTR_RAM_AW-1:`PTR_HIGH_LSB];
    end
  end

  // Reset value is a choice: software must load the pointer before use anyway
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_high_r <= `PTR_RESET_HIGH;
    end else if (clk_en) begin
      ptr_high_r <= ptr_high_nxt;
    end
  end

  // Lower address register, bit 7 included
  always_comb begin
    ptr_low_nxt = ptr_low_r;
    if (low_wr) begin
      ptr_low_nxt = reg_wdata;
    end else if (data_access) begin
      ptr_low_nxt = ptr_step[`PTR_LOW_MSB:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_low_r <= `PTR_RESET_LOW;
    end else if (clk_en) begin
      ptr_low_r <= ptr_low_nxt;
    end
  end

  // Registers are sampled at the read strobe so a later write cannot alter the answer
  always_comb begin
    rd_sel_nxt  = ram_pointer_pkg::SEL_NONE;
    rd_hold_nxt = `PTR_UNMAPPED_READ;
    if (reg_rd) begin
      rd_sel_nxt  = sel;
      rd_hold_nxt = reg_view(sel, ptr_high_r, ptr_low_r);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_sel_r  <= ram_pointer_pkg::SEL_NONE;
      rd_hold_r <= 8'h00;
    end else if (clk_en) begin
      rd_sel_r  <= rd_sel_nxt;
      rd_hold_r <= rd_hold_nxt;
    end
  end

  // RAM read data is already registered, so the data port answer is the RAM output
  always_comb begin
    if (rd_sel_r == ram_pointer_pkg::SEL_DATA) begin
      reg_rdata = ram_rdata;
    end else begin
      reg_rdata = rd_hold_r;
    end
  end

  pointer_ram u_ram (
    .core_clk (core_clk),
    .clk_en   (clk_en),
    .addr     (ptr_cur),
    .wr_en    (ram_wr),
    .wr_data  (reg_wdata),
    .rd_data  (ram_rdata)
  );

  assign ptr_addr = ptr_cur;
endmodule : ram_pointer
`default_nettype wire

// ===== design/ram_pointer_cfg.svh
// Register offsets, field positions and sizes of the auto-increment RAM pointer.
// Included by the package and the design modules.
`ifndef RAM_POINTER_CFG_SVH
`define RAM_POINTER_CFG_SVH
`define PTR_ADDR_W        16
`define PTR_DATA_W        8
`define PTR_HIGH_OFFSET   16'h7FE3
`define PTR_LOW_OFFSET    16'h7FE4
`define PTR_DATA_OFFSET   16'h7FE5
`define PTR_RAM_AW        15
`define PTR_HIGH_MSB      6
`define PTR_HIGH_LSB      8
`define PTR_HIGH_W        7
`define PTR_LOW_MSB       7
`define PTR_RESET_HIGH    7'h00
`define PTR_RESET_LOW     8'h00
`define PTR_UNMAPPED_READ 8'h00
`define PTR_BULK_BUF_SIZE 64
`define PTR_RAM_DEPTH     1024
`define PTR_RAM_IDX_W     10
`endif

// ===== design/ram_pointer_pkg.sv
// Types shared by the RAM pointer design files.
// Assumes ram_pointer_cfg.svh is on the include path.
`default_nettype none
`include "ram_pointer_cfg.svh"
package ram_pointer_pkg;
  typedef logic [`PTR_RAM_AW-1:0] ram_addr_type;
  typedef logic [`PTR_DATA_W-1:0] byte_type;
  typedef enum logic [1:0] {SEL_NONE, SEL_HIGH, SEL_LOW, SEL_DATA} reg_sel_type;
endpackage : ram_pointer_pkg
`default_nettype wire

// ===== dv/mcu_model.sv
// Microcontroller side: master of the pointer register port.
// Assumes strobes taken on the rising edge, read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
  // Clock
  input wire logic  core_clk,
  // Register port
  output var logic [15:0] reg_addr = 16'h0000,
  output var logic [7:0]  reg_wdata = 8'h00,
  output var logic        reg_wr = 1'b0,
  output var logic        reg_rd = 1'b0,
  input wire logic [7:0]  reg_rdata
);
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Released bus shows the inverse so a stale byte is never mistaken for data
    reg_wdata <= ~d;
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : mcu_model
`default_nettype wire

// ===== dv/ram_pointer_sva.sv
// Assertions on the RAM pointer register port.
// Bound to ram_pointer; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "ram_pointer_cfg.svh"
module ram_pointer_sva (
  // Clock, reset, enable
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [14:0] ptr_addr
);
  wire hi = clk_en && reg_addr == `PTR_HIGH_OFFSET;
  wire lo = clk_en && reg_addr == `PTR_LOW_OFFSET;
  wire dp = clk_en && reg_addr == `PTR_DATA_OFFSET;
  wire un = clk_en && !hi && !lo && !dp;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_hi_load: assert property (reg_wr && hi |=> ptr_addr[14:8] == $past(reg_wdata[6:0])) else $error("hi load");
  a_lo_load: assert property (reg_wr && lo |=> ptr_addr[7:0] == $past(reg_wdata)) else $error("lo load");
  a_data_step: assert property ((reg_wr || reg_rd) && dp |=> ptr_addr == $past(ptr_addr) + 15'h1) else $error("step");
  a_idle_hold: assert property (clk_en && !reg_wr && !reg_rd |=> $stable(ptr_addr)) else $error("idle");
  a_freeze_hold: assert property (!clk_en |=> $stable(ptr_addr)) else $error("freeze");
  a_hi_read: assert property (reg_rd && hi |=> reg_rdata == {1'b0, $past(ptr_addr[14:8])}) else $error("hi rd");
  a_lo_read: assert property (reg_rd && lo |=> reg_rdata == $past(ptr_addr[7:0])) else $error("lo rd");
  a_unmapped_read: assert property (reg_rd && un |=> reg_rdata == 8'h00) else $error("unmapped");
endmodule : ram_pointer_sva
bind ram_pointer ram_pointer_sva chk (
  .core_clk  (core_clk),
  .rst       (rst),
  .clk_en    (clk_en),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .ptr_addr  (ptr_addr)
);
`default_nettype wire

// ===== dv/ram_pointer_tb.sv
// Self-checking bench for ram_pointer.
// Assumes the design and mcu_model sources are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ram_pointer_cfg.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module ram_pointer_tb;
  logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [14:0] ptr_addr;
  int num_errors = 0, checks_done = 0;
  always #25 core_clk = ~core_clk;
  mcu_model mcu (
    .core_clk  (core_clk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );
  ram_pointer dut (
    .core_clk  (core_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .ptr_addr  (ptr_addr)
  );
  task load(input logic [14:0] p);
    mcu.wr(`PTR_HIGH_OFFSET, {1'b0, p[14:8]});
    mcu.wr(`PTR_LOW_OFFSET, p[7:0]);
  endtask : load
  task t_regs;
    @(negedge core_clk);
    `CHK("reset", 15'h0000, ptr_addr)
    load(15'h12A5);
    `CHK("loaded", 15'h12A5, ptr_addr)
    mcu.wr(`PTR_HIGH_OFFSET, 8'hFF);
    mcu.rd(`PTR_HIGH_OFFSET, d);
    `CHK("high", 8'h7F, d)
    mcu.rd(`PTR_LOW_OFFSET, d);
    `CHK("low", 8'hA5, d)
    `CHK("ptr", 15'h7FA5, ptr_addr)
    $display("t_regs done");
  endtask : t_regs
  task t_stream;
    load(15'h0040);
    for (int i = 0; i < `PTR_BULK_BUF_SIZE; i++) mcu.wr(`PTR_DATA_OFFSET, 8'(i) ^ 8'h5A);
    `CHK("ptr", 15'h0080, ptr_addr)
    load(15'h0040);
    for (int i = 0; i < `PTR_BULK_BUF_SIZE; i++) begin
      mcu.rd(`PTR_DATA_OFFSET, d);
      `CHK("data", 8'(i) ^ 8'h5A, d)
    end
    $display("t_stream done");
  endtask : t_stream
  task t_wrap;
    load(15'h7FFF);
    mcu.wr(`PTR_DATA_OFFSET, 8'h3C);
    `CHK("wrap", 15'h0000, ptr_addr)
    mcu.wr(16'h7FE6, 8'h11);
    `CHK("ignored", 15'h0000, ptr_addr)
    mcu.rd(16'h0000, d);
    `CHK("unmapped", 8'h00, d)
    @(posedge core_clk) clk_en <= 1'b0;
    mcu.wr(`PTR_LOW_OFFSET, 8'h77);
    @(posedge core_clk) clk_en <= 1'b1;
    @(negedge core_clk);
    `CHK("frozen", 15'h0000, ptr_addr)
    $display("t_wrap done");
  endtask : t_wrap
  task t_reset;
    load(15'h0123);
    @(posedge core_clk) rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `CHK("rerst ptr", 15'h0000, ptr_addr)
    mcu.rd(`PTR_LOW_OFFSET, d);
    `CHK("rerst low", 8'h00, d)
    $display("t_reset done");
  endtask : t_reset
  task results;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_stream;
    t_wrap;
    t_reset;
    results;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    results;
  end
endmodule : ram_pointer_tb
`default_nettype wire
